// [hw/bsr_pkg.sv]
// Constants and types shared by the buffer sequencer and its poll encoder.
// Assumes a single 100 MHz core clock and dwell times held in milliseconds.
package bsr_pkg;

    typedef enum logic [1:0] {
        single_pass_mode,
        continuous_loop_mode,
        stepwise_mode
    } bsr_pmode_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_DWELL
    } bsr_state_e;

    localparam int         DEPTH    = 100;
    localparam logic [6:0] PTR_LAST = 7'h63;
    localparam logic [6:0] PTR_FIRST = 7'h00;

    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

    // A range switch eats this much of the entry's dwell, in ms.
    localparam logic [15:0] RANGE_SWITCH_MS = 16'h0002;

    localparam logic [3:0] auto_range_select = 4'h0;
    localparam logic [3:0] RANGE_LAST        = 4'h9;

    localparam logic [1:0] TRIG_PANEL = 2'h0;
    localparam logic [1:0] TRIG_BUS   = 2'h1;
    localparam logic [1:0] TRIG_EXT   = 2'h2;

    // Magnitudes count steps of the finest resolution; index is the range.
    localparam logic [39:0] RNG_MAX [10] = '{
        40'h2f08236400, 40'h0000000f9f, 40'h0000009c36, 40'h0000061a1c,
        40'h00003d0518, 40'h00026232f0, 40'h0017d5fd60, 40'h00ee5be5c0,
        40'h094f96f980, 40'h2f08236400};
    localparam logic [39:0] RNG_LSB [10] = '{
        40'h0000000001, 40'h0000000001, 40'h000000000a, 40'h0000000064,
        40'h00000003e8, 40'h0000002710, 40'h00000186a0, 40'h00000f4240,
        40'h0000989680, 40'h0005f5e100};

    // Status byte layout.
    localparam int SB_SRQ  = 6;
    localparam int SB_ERR  = 5;
    localparam logic [7:0] SB_RESET = 8'h00;

endpackage

// [hw/bsr_poll.sv]
// Serial-poll status byte encoder with a sticky service request.
// Assumes one-cycle event pulses on the core clock and a one-cycle poll read.
module bsr_poll (
    input  wire logic       i_core_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_clear,
    input  wire logic       i_ev_illegal_cmd,
    input  wire logic       i_ev_illegal_opt,
    input  wire logic       i_ev_no_remote,
    input  wire logic       i_ev_limit,
    input  wire logic       i_ev_eob,
    input  wire logic       i_ev_eod,
    input  wire logic       i_ev_port,
    input  wire logic [4:0] i_srq_mask,
    input  wire logic       i_poll_rd,
    output logic      [7:0] o_status,
    output logic            o_srq
);
    logic [2:0] err, next_err, err_set;
    logic [3:0] dat, next_dat, dat_set;
    logic       next_srq, req;
    logic [7:0] next_status;

    always_comb begin
        err_set = {i_ev_no_remote, i_ev_illegal_opt, i_ev_illegal_cmd};
        dat_set = {i_ev_port, i_ev_eod, i_ev_eob, i_ev_limit};
        req = ((|err_set) & i_srq_mask[0]) | (i_ev_limit & i_srq_mask[1])
            | (i_ev_eob & i_srq_mask[2]) | (i_ev_eod & i_srq_mask[3])
            | (i_ev_port & i_srq_mask[4]);
        // A poll clears what it reported; a new event in that cycle stays.
        next_err = err;
        next_dat = dat;
        if (i_poll_rd && o_status[bsr_pkg::SB_ERR]) begin
            next_err = '0;
        end else if (i_poll_rd) begin
            next_dat = '0;
        end
        next_err = next_err | err_set;
        next_dat = next_dat | dat_set;
        next_srq = (o_srq & ~i_poll_rd) | req;
        if (i_clear) begin
            next_err = '0;
            next_dat = '0;
            next_srq = 1'b0;
        end
        next_status = bsr_pkg::SB_RESET;
        next_status[bsr_pkg::SB_SRQ] = next_srq;
        next_status[bsr_pkg::SB_ERR] = |next_err;
        if (|next_err) begin
            next_status[2:0] = next_err;
        end else begin
            next_status[3:0] = next_dat;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            err      <= '0;
            dat      <= '0;
            o_srq    <= 1'b0;
            o_status <= bsr_pkg::SB_RESET;
        end else begin
            err      <= next_err;
            dat      <= next_dat;
            o_srq    <= next_srq;
            o_status <= next_status;
        end
    end

    AST_SRQ_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        o_srq && !i_poll_rd && !i_clear |=> o_srq)
        else $error("service request dropped without a poll");
    AST_SRQ_BIT: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        o_status[bsr_pkg::SB_SRQ] == o_srq)
        else $error("status bit 6 differs from service request");
    AST_OPT_BIT: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        i_ev_illegal_opt && i_srq_mask[0] && !i_clear
        |=> o_srq && o_status[5] && o_status[1])
        else $error("over range option error not reported");
    AST_ERR_B3: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        i_ev_illegal_cmd && !i_clear |=> o_status[5] && o_status[0]
        && !o_status[3])
        else $error("illegal command not in error layout");
    AST_DATA_EOB: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        !o_status[5] && !i_clear && i_ev_eob && !(|err_set)
        |=> !o_status[5] && o_status[1])
        else $error("end of buffer not in data layout");
endmodule

// [hw/bsr_top.sv]
// Buffer sequencer, range validation and status encoding for a source.
// Assumes command strobes come from same-clock decode logic; panel button,
// external trigger, limit and input port pins are asynchronous.
module bsr_top #(
    parameter int unsigned P_MS_CYCLES = bsr_pkg::MS_CYCLES
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_dev_clear,
    input  wire logic        i_mode_wr,
    input  wire logic [1:0]  i_mode_sel,
    input  wire logic        i_range_wr,
    input  wire logic [3:0]  i_range_sel,
    input  wire logic        i_src_wr,
    input  wire logic [6:0]  i_src_addr,
    input  wire logic [39:0] i_src_mag,
    input  wire logic [15:0] i_src_dwell,
    input  wire logic [1:0]  i_trig_sel,
    input  wire logic        i_bus_trig,
    input  wire logic        i_panel_btn,
    input  wire logic        i_ext_trig,
    input  wire logic        i_limit,
    input  wire logic [3:0]  i_in_port,
    input  wire logic        i_illegal_cmd,
    input  wire logic        i_no_remote,
    input  wire logic [4:0]  i_srq_mask,
    input  wire logic        i_poll_rd,
    output logic      [7:0]  o_status,
    output logic             o_srq,
    output logic      [39:0] o_src_value,
    output logic      [3:0]  o_src_range,
    output logic      [6:0]  o_ptr,
    output logic             o_running,
    output logic      [1:0]  o_mode,
    output logic      [3:0]  o_range
);
    logic [39:0] buf_val [bsr_pkg::DEPTH];
    logic [3:0]  buf_rng [bsr_pkg::DEPTH];
    logic [15:0] buf_dwl [bsr_pkg::DEPTH];

    logic [6:0] pin_raw, pin_s1, pin_s2, pin_s3;
    logic       btn_rise, ext_rise, lim_rise, port_chg, trig;

    bsr_pkg::bsr_pmode_e mode, next_mode;
    bsr_pkg::bsr_state_e st, next_st;
    logic [3:0]  range, next_range, auto_rng, eff_rng;
    logic [6:0]  ptr, next_ptr;
    logic [15:0] rem, next_rem, charged;
    logic [31:0] mscnt, next_mscnt;
    logic        zero_hold, next_zero_hold, run, next_run;
    logic        ev_opt, next_ev_opt, ev_eob, next_ev_eob;
    logic        ev_eod, next_ev_eod;
    logic [39:0] out_val, next_out_val;
    logic [3:0]  out_rng, next_out_rng;
    logic        over, under, mem_we, cmd_bad;
    logic [39:0] ent_val;
    logic [3:0]  ent_rng;
    logic [15:0] ent_dwl;
    logic        ms_tick;

    // Asynchronous pins pass two flops; the third stage is for edges only.
    genvar g;
    generate
        for (g = 0; g < 7; g++) begin : g_sync
            always_ff @(posedge i_core_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    pin_s1[g] <= 1'b0;
                    pin_s2[g] <= 1'b0;
                    pin_s3[g] <= 1'b0;
                end else begin
                    pin_s1[g] <= pin_raw[g];
                    pin_s2[g] <= pin_s1[g];
                    pin_s3[g] <= pin_s2[g];
                end
            end
        end
    endgenerate

    always_comb begin
        pin_raw  = {i_in_port, i_limit, i_ext_trig, i_panel_btn};
        btn_rise = pin_s2[0] & ~pin_s3[0];
        ext_rise = pin_s2[1] & ~pin_s3[1];
        lim_rise = pin_s2[2] & ~pin_s3[2];
        port_chg = |(pin_s2[6:3] ^ pin_s3[6:3]);
        unique case (i_trig_sel)
            bsr_pkg::TRIG_PANEL: trig = btn_rise;
            bsr_pkg::TRIG_BUS:   trig = i_bus_trig;
            default:             trig = ext_rise;
        endcase
    end

    // Source command check. Auto ranging searches from the widest range
    // down so the finest range that still holds the value wins.
    always_comb begin
        auto_rng = bsr_pkg::RANGE_LAST;
        for (int r = 9; r >= 1; r--) begin
            if (i_src_mag <= bsr_pkg::RNG_MAX[r]) begin
                auto_rng = 4'(r);
            end
        end
        eff_rng = (range == bsr_pkg::auto_range_select) ? auto_rng : range;
        over    = i_src_mag > bsr_pkg::RNG_MAX[range];
        under   = i_src_mag < bsr_pkg::RNG_LSB[eff_rng];
        mem_we  = i_src_wr && !over;
        cmd_bad = (i_src_wr && over)
                || (i_mode_wr && i_mode_sel == 2'h3)
                || (i_range_wr && i_range_sel > bsr_pkg::RANGE_LAST);
    end

    // Range commands do not touch this array; only new writes use range.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int k = 0; k < bsr_pkg::DEPTH; k++) begin
                buf_dwl[k] <= '0;
            end
        end else if (mem_we) begin
            buf_val[i_src_addr] <= under ? '0 : i_src_mag;
            buf_rng[i_src_addr] <= eff_rng;
            buf_dwl[i_src_addr] <= i_src_dwell;
        end
    end

    always_comb begin
        ent_val = buf_val[ptr];
        ent_rng = buf_rng[ptr];
        ent_dwl = buf_dwl[ptr];
        ms_tick = mscnt == 32'(P_MS_CYCLES - 1);
        charged = ent_dwl;
        if (ent_rng != out_rng) begin
            charged = (ent_dwl > bsr_pkg::RANGE_SWITCH_MS)
                    ? ent_dwl - bsr_pkg::RANGE_SWITCH_MS : 16'h0001;
        end
    end

    always_comb begin
        next_mode      = mode;
        next_range     = range;
        next_st        = st;
        next_ptr       = ptr;
        next_rem       = rem;
        next_mscnt     = mscnt;
        next_zero_hold = zero_hold;
        next_run       = run;
        next_out_val   = out_val;
        next_out_rng   = out_rng;
        next_ev_opt    = cmd_bad;
        next_ev_eob    = 1'b0;
        next_ev_eod    = 1'b0;
        unique case (st)
            bsr_pkg::ST_IDLE: begin
                if (trig) begin
                    next_ptr = (zero_hold || ptr == bsr_pkg::PTR_LAST)
                             ? bsr_pkg::PTR_FIRST : ptr + 7'h01;
                    next_zero_hold = 1'b0;
                    next_st  = bsr_pkg::ST_LOAD;
                    next_run = mode != bsr_pkg::stepwise_mode;
                end
            end
            bsr_pkg::ST_LOAD: begin
                if (ent_dwl == '0) begin
                    next_ev_eob = 1'b1;
                    if (mode == bsr_pkg::continuous_loop_mode
                            && ptr != bsr_pkg::PTR_FIRST) begin
                        next_ptr = bsr_pkg::PTR_FIRST;
                    end else begin
                        next_st  = bsr_pkg::ST_IDLE;
                        next_run = 1'b0;
                        next_zero_hold = mode == bsr_pkg::stepwise_mode;
                    end
                end else begin
                    next_out_val = ent_val;
                    next_out_rng = ent_rng;
                    if (mode == bsr_pkg::stepwise_mode) begin
                        next_st = bsr_pkg::ST_IDLE;
                    end else begin
                        next_rem   = charged;
                        next_mscnt = '0;
                        next_st    = bsr_pkg::ST_DWELL;
                    end
                end
            end
            bsr_pkg::ST_DWELL: begin
                next_mscnt = mscnt + 32'h1;
                if (ms_tick) begin
                    next_mscnt = '0;
                    next_rem   = rem - 16'h0001;
                    if (rem <= 16'h0001) begin
                        next_ev_eod = 1'b1;
                        next_st     = bsr_pkg::ST_LOAD;
                        next_ptr    = ptr + 7'h01;
                        if (ptr == bsr_pkg::PTR_LAST) begin
                            next_ev_eob = 1'b1;
                            next_ptr    = bsr_pkg::PTR_FIRST;
                            if (mode == bsr_pkg::single_pass_mode) begin
                                next_st  = bsr_pkg::ST_IDLE;
                                next_run = 1'b0;
                            end
                        end
                    end
                end
            end
        endcase
        // A trigger while a timed program runs is the stop stimulus.
        if (st != bsr_pkg::ST_IDLE && trig
                && mode != bsr_pkg::stepwise_mode) begin
            next_st  = bsr_pkg::ST_IDLE;
            next_run = 1'b0;
        end
        if (i_mode_wr && i_mode_sel != 2'h3) begin
            next_mode = bsr_pkg::bsr_pmode_e'(i_mode_sel);
            next_st   = bsr_pkg::ST_IDLE;
            next_run  = 1'b0;
        end
        if (i_range_wr && i_range_sel <= bsr_pkg::RANGE_LAST) begin
            next_range = i_range_sel;
        end
        if (i_dev_clear) begin
            next_mode      = bsr_pkg::stepwise_mode;
            next_range     = bsr_pkg::auto_range_select;
            next_st        = bsr_pkg::ST_IDLE;
            next_run       = 1'b0;
            next_zero_hold = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mode      <= bsr_pkg::stepwise_mode;
            range     <= bsr_pkg::auto_range_select;
            st        <= bsr_pkg::ST_IDLE;
            ptr       <= bsr_pkg::PTR_FIRST;
            rem       <= '0;
            mscnt     <= '0;
            zero_hold <= 1'b0;
            run       <= 1'b0;
            out_val   <= '0;
            out_rng   <= bsr_pkg::auto_range_select;
            ev_opt    <= 1'b0;
            ev_eob    <= 1'b0;
            ev_eod    <= 1'b0;
        end else begin
            mode      <= next_mode;
            range     <= next_range;
            st        <= next_st;
            ptr       <= next_ptr;
            rem       <= next_rem;
            mscnt     <= next_mscnt;
            zero_hold <= next_zero_hold;
            run       <= next_run;
            out_val   <= next_out_val;
            out_rng   <= next_out_rng;
            ev_opt    <= next_ev_opt;
            ev_eob    <= next_ev_eob;
            ev_eod    <= next_ev_eod;
        end
    end

    always_comb begin
        o_src_value = out_val;
        o_src_range = out_rng;
        o_ptr       = ptr;
        o_running   = run;
        o_mode      = mode;
        o_range     = range;
    end

    bsr_poll u_poll (
        .i_core_clk       (i_core_clk),
        .i_nrst           (i_nrst),
        .i_clear          (i_dev_clear),
        .i_ev_illegal_cmd (i_illegal_cmd),
        .i_ev_illegal_opt (ev_opt),
        .i_ev_no_remote   (i_no_remote),
        .i_ev_limit       (lim_rise),
        .i_ev_eob         (ev_eob),
        .i_ev_eod         (ev_eod),
        .i_ev_port        (port_chg),
        .i_srq_mask       (i_srq_mask),
        .i_poll_rd        (i_poll_rd),
        .o_status         (o_status),
        .o_srq            (o_srq)
    );

    sequence s_step_trig;
        st == bsr_pkg::ST_IDLE && trig && mode == bsr_pkg::stepwise_mode
        && !i_dev_clear && !i_mode_wr;
    endsequence
    sequence s_zero_load;
        st == bsr_pkg::ST_LOAD && ent_dwl == '0 && !trig && !i_mode_wr
        && !i_dev_clear;
    endsequence

    AST_CLEAR_DEF: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        i_dev_clear |=> mode == bsr_pkg::stepwise_mode && !o_running)
        else $error("device clear did not select step mode");
    AST_CLEAR_RNG: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        i_dev_clear |=> o_range == bsr_pkg::auto_range_select)
        else $error("device clear did not select auto range");
    AST_STEP_ONE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        s_step_trig and (!zero_hold && ptr != bsr_pkg::PTR_LAST)
        |=> o_ptr == $past(o_ptr) + 7'h01 ##1 st == bsr_pkg::ST_IDLE)
        else $error("step trigger did not advance exactly once");
    AST_STEP_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        s_zero_load and (mode == bsr_pkg::stepwise_mode)
        |=> zero_hold && o_ptr == $past(o_ptr))
        else $error("zero dwell in step mode moved the pointer");
    AST_SINGLE_STOP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        s_zero_load and (mode == bsr_pkg::single_pass_mode)
        |=> !o_running && st == bsr_pkg::ST_IDLE)
        else $error("single pass did not stop at zero dwell");
    AST_CONT_WRAP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        s_zero_load and (mode == bsr_pkg::continuous_loop_mode && ptr != '0)
        |=> o_ptr == '0 && st == bsr_pkg::ST_LOAD)
        else $error("continuous mode did not return to first location");
    AST_OVER: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        i_src_wr && i_src_mag > bsr_pkg::RNG_MAX[range]
        |=> ev_opt && buf_dwl[$past(i_src_addr)] == $past(
            buf_dwl[i_src_addr]))
        else $error("over range value was not rejected");
    AST_AUTO: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        i_src_wr && range == bsr_pkg::auto_range_select && !i_mode_wr
        && !i_range_wr && i_src_mag <= bsr_pkg::RNG_MAX[0] |=> !ev_opt)
        else $error("auto range flagged a value it can hold");
    AST_UNDER: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        mem_we && i_src_mag < bsr_pkg::RNG_LSB[eff_rng]
        |=> buf_val[$past(i_src_addr)] == '0)
        else $error("under range value not stored as zero");
    AST_CHARGE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        st == bsr_pkg::ST_LOAD && ent_dwl > 16'h0002 && ent_rng != out_rng
        && mode != bsr_pkg::stepwise_mode && !trig && !i_mode_wr
        && !i_dev_clear |=> rem == $past(ent_dwl) - 16'h0002)
        else $error("range change not charged to dwell");
endmodule

// [test/bsr_ctl_model.sv]
// Bus controller model that answers a service request with a serial poll.
// Assumes status byte and request are registered on the rising clock edge.
module bsr_ctl_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_srq,
    input  wire logic [7:0] i_status,
    output logic            o_poll_rd,
    output logic      [7:0] o_last
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_n = 0;
    // A slow answer: the request must stay up until the poll is taken.
    always @(negedge i_core_clk) begin
        wait_n    <= i_srq ? wait_n + 1 : 0;
        o_poll_rd <= i_srq && !o_poll_rd && wait_n >= 3;
    end
    always @(posedge i_core_clk)
        if (o_poll_rd)
            o_last <= i_status;
endmodule

// [test/bsr_top_tb.sv]
// Self-checking bench for the buffer sequencer and its status byte.
// Assumes a 100 MHz clock and a millisecond shortened to ten cycles.
module bsr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, nrst, clr, mwr, rwr, swr, btrig, pbtn, etrig;
    logic        poll, srq, run, lim, icmd, nrem;
    logic [1:0]  msel, tsel, mode;
    logic [3:0]  rsel, rng, port, srng;
    logic [6:0]  saddr, ptr;
    logic [39:0] smag, val;
    logic [15:0] sdwell;
    logic [4:0]  mask;
    logic [7:0]  status, last;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          n_cyc;
    typedef struct packed {
        logic [3:0] m, r;
        logic [1:0] em;
        logic [3:0] er;
        logic [7:0] es;
    } bsr_row_s;
    bsr_row_s rows [5] = '{
        '{4'h0, 4'h1, 2'h0, 4'h1, 8'h00}, '{4'h1, 4'h9, 2'h1, 4'h9, 8'h00},
        '{4'h2, 4'h0, 2'h2, 4'h0, 8'h00}, '{4'h3, 4'h5, 2'h2, 4'h5, 8'h22},
        '{4'h0, 4'ha, 2'h0, 4'h0, 8'h22}};

    bsr_top #(.P_MS_CYCLES(10)) uut (
        .i_core_clk(clk), .i_nrst(nrst), .i_dev_clear(clr), .i_mode_wr(mwr),
        .i_mode_sel(msel), .i_range_wr(rwr), .i_range_sel(rsel),
        .i_src_wr(swr), .i_src_addr(saddr), .i_src_mag(smag),
        .i_src_dwell(sdwell), .i_trig_sel(tsel), .i_bus_trig(btrig),
        .i_panel_btn(pbtn), .i_ext_trig(etrig), .i_limit(lim),
        .i_in_port(port), .i_illegal_cmd(icmd), .i_no_remote(nrem),
        .i_srq_mask(mask), .i_poll_rd(poll), .o_status(status), .o_srq(srq),
        .o_src_value(val), .o_src_range(srng), .o_ptr(ptr), .o_running(run),
        .o_mode(mode), .o_range(rng));
    bsr_ctl_model ctl (.i_core_clk(clk), .i_srq(srq), .i_status(status),
                       .o_poll_rd(poll), .o_last(last));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string nm, input logic [39:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Kind 0 writes the mode, 1 the range, 2 pulses device clear.
    task automatic cmd(input int k, input logic [3:0] v);
        msel = v[1:0];
        rsel = v;
        mwr  = (k == 0);
        rwr  = (k == 1);
        clr  = (k == 2);
        tick(1);
        {mwr, rwr, clr} = 3'b000;
        tick(3);
    endtask
    task automatic wr_src(input logic [6:0] a, input logic [39:0] m,
                          input logic [15:0] d);
        saddr = a;
        smag  = m;
        sdwell = d;
        swr   = 1'b1;
        tick(1);
        swr = 1'b0;
        tick(3);
    endtask
    // Pins are held several cycles since they pass a synchroniser.
    task automatic trig(input logic [1:0] s);
        tsel  = s;
        btrig = (s == 2'h1);
        pbtn  = (s == 2'h0);
        etrig = (s == 2'h2);
        tick(1);
        btrig = 1'b0;
        tick(4);
        {pbtn, etrig} = 2'b00;
        tick(6);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        {nrst, clr, mwr, rwr, swr, btrig, pbtn, etrig} = 8'h00;
        {lim, icmd, nrem, port} = 7'h00;
        {msel, tsel, rsel, saddr, mask} = 20'h00000;
        {smag, sdwell} = 56'h0;
        tick(5);
        nrst = 1'b1;
        tick(1);
        chk("mode", 2'h2, mode);
        chk("range", 4'h0, rng);
        chk("srq", 1'b0, srq);
        foreach (rows[i]) begin
            cmd(0, rows[i].m);
            cmd(1, rows[i].r);
            chk("mode", rows[i].em, mode);
            chk("range", rows[i].er, rng);
            chk("status", rows[i].es, status);
            cmd(2, 4'h0);
            chk("mode", 2'h2, mode);
            chk("range", 4'h0, rng);
        end
        $display("row test done");
        mask = 5'h01;
        wr_src(7'h00, 40'h5, 16'h0001);
        wr_src(7'h01, 40'h2f08236400, 16'h0001);
        chk("status", 8'h00, status);
        cmd(1, 4'h1);
        wr_src(7'h01, 40'h800, 16'h0001);
        wr_src(7'h03, 40'h1000, 16'h0001);
        tick(6);
        chk("poll byte", 8'h62, last);
        chk("srq", 1'b0, srq);
        cmd(1, 4'h3);
        wr_src(7'h02, 40'h10, 16'h0005);
        cmd(1, 4'h0);
        trig(2'h1);
        chk("ptr", 7'h01, ptr);
        chk("value", 40'h800, val);
        trig(2'h0);
        chk("ptr", 7'h02, ptr);
        chk("value", 40'h0, val);
        chk("src range", 4'h3, srng);
        trig(2'h2);
        chk("ptr", 7'h03, ptr);
        chk("status", 8'h02, status);
        trig(2'h1);
        chk("ptr", 7'h00, ptr);
        chk("src range", 4'h1, srng);
        $display("step test done");
        cmd(0, 4'h0);
        trig(2'h1);
        n_cyc = 0;
        while (run && n_cyc < 100) begin
            tick(1);
            n_cyc++;
        end
        // One ms, then five ms less the 2 ms range switch, plus one trigger and three
        // load cycles, minus the eleven cycles already spent inside trig.
        chk("run cycles", 33, n_cyc);
        chk("ptr", 7'h03, ptr);
        chk("running", 1'b0, run);
        cmd(0, 4'h1);
        trig(2'h1);
        tick(60);
        chk("running", 1'b1, run);
        trig(2'h1);
        chk("running", 1'b0, run);
        chk("status", 8'h06, status);
        $display("run test done");
        cmd(2, 4'h0);
        {lim, port} = 5'h11;
        tick(8);
        chk("status", 8'h09, status);
        {icmd, nrem} = 2'b11;
        tick(1);
        {icmd, nrem} = 2'b00;
        tick(2);
        chk("status", 8'h65, status);
        {lim, port} = 5'h00;
        tick(4);
        chk("poll byte", 8'h65, last);
        $display("status test done");
        // Reset with the sequencer idle in step mode and every pin idle, so no false edge follows it.
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        tick(1);
        chk("ptr", 7'h00, ptr);
        chk("status", 8'h00, status);
        chk("value", 40'h0, val);
        chk("src range", 4'h0, srng);
        $display("reset test done");
        wrap_up();
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
endmodule
